// *** tb/hsr_cpu_model.sv ***
// Behavioural CPU side issuing the halt instruction
`timescale 1ns/1ps
module hsr_cpu_model (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic go,
  input  wire logic cpu_clk_en,
  output logic      halt_exec
);
  //////////////////////////////////////////////////////////////////////
  // No pin-clocked unit started
  // A gated core cannot execute, so no halt while stopped
  always_ff @(posedge clock)
  begin
    halt_exec <= !srst && go && cpu_clk_en;
  end
endmodule : hsr_cpu_model

// *** tb/test_halt_standby_release_control.sv ***
// Testbench for the halt standby release control
`timescale 1ns/1ps
`include "hsr_params.svh"
module test_halt_standby_release_control;
  typedef struct packed {
    logic       ie;
    logic [7:0] mask;
    logic [7:0] flag;
    logic       prs;
    logic [1:0] ctrl;
    logic       vec;
    logic [2:0] run;
  } hsr_row_s;
  hsr_row_s rows [4] = '{
    '{1'h1, 8'hFE, 8'h01, 1'h0, 2'h3, 1'h1, 3'h7},
    '{1'h0, 8'h00, 8'h80, 1'h1, 2'h3, 1'h0, 3'h4},
    '{1'h1, 8'h7F, 8'h80, 1'h0, 2'h1, 1'h1, 3'h6},
    '{1'h0, 8'hF0, 8'h08, 1'h0, 2'h2, 1'h0, 3'h5}};
  logic clock, srst, go, halt_exec, int_ack_en, prs_clk_stop, lsosc_sw_stop_opt;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  irq_flag, irq_mask;
  logic        cpu_clk_en, mem_retain, g;
  hsr_pkg::hsr_run_s    run;
  hsr_pkg::hsr_resume_s resume;
  int fail_count = 0;
  int compares = 0;
  int n;

  hsr_halt_ctrl dut_u (.clock, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .halt_exec, .irq_flag, .irq_mask,
    .int_ack_en, .prs_clk_stop, .lsosc_sw_stop_opt, .cpu_clk_en, .mem_retain, .run,
    .resume);
  hsr_cpu_model cpu_u (.clock, .srst, .go, .cpu_clk_en, .halt_exec);

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("Mismatches %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Handshake seen at negedge, released after the next rising edge
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ah, wh, bh;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    bh = 1'h0;
    while (!bh)
    begin
      @(negedge clock);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bready && s_axi_bvalid;
      if (bh)
        chk(s_axi_bresp, r);
      @(posedge clock);
      if (ah)
        s_axi_awvalid <= 1'h0;
      if (wh)
        s_axi_wvalid <= 1'h0;
      if (bh)
        s_axi_bready <= 1'h0;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ah, rh;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    rh = 1'h0;
    while (!rh)
    begin
      @(negedge clock);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rready && s_axi_rvalid;
      if (rh)
        chk({s_axi_rresp, s_axi_rdata}, {r, d});
      @(posedge clock);
      if (ah)
        s_axi_arvalid <= 1'h0;
      if (rh)
        s_axi_rready <= 1'h0;
    end
  endtask : axi_rd

  task automatic do_reset(input logic opt);
    @(posedge clock);
    srst <= 1'h1;
    lsosc_sw_stop_opt <= opt;
    repeat (10) @(posedge clock);
    #1;
    chk({cpu_clk_en, mem_retain, run, resume}, 8'h80);
    @(posedge clock);
    srst <= 1'h0;
    @(posedge clock);
    #1;
    chk({run.wdt_clk_en, resume}, 4'h9);
    @(posedge clock);
    #1;
    chk(resume, 3'h0);
  endtask : do_reset

  task automatic do_halt;
    @(posedge clock);
    go <= 1'h1;
    @(posedge clock);
    go <= 1'h0;
    @(posedge clock);
    #1;
  endtask : do_halt

  // Bounded so a missing resume shows as a count mismatch
  task automatic wait_res(output int k, output logic gated);
    k = 0;
    gated = 1'h0;
    do
    begin
      @(posedge clock);
      #1;
      k++;
      if (cpu_clk_en !== 1'h1)
        gated = 1'h1;
    end
    while (!(resume.vec || resume.next) && k < 30);
  endtask : wait_res

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  initial
  begin
    #200000;
    fail_count++;
    summarize();
  end

  initial
  begin
    {srst, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h10;
    {s_axi_arvalid, s_axi_rready, int_ack_en, prs_clk_stop, lsosc_sw_stop_opt} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    irq_flag = 8'h00;
    irq_mask = 8'hFF;
    do_reset(1'h0);
    axi_rd(`HSR_OFS_CTRL, 32'h0, `HSR_RESP_OKAY);
    axi_rd(`HSR_OFS_STAT, 32'h8, `HSR_RESP_OKAY);
    axi_rd(32'h10, 32'h0, `HSR_RESP_SLVERR);
    axi_wr(32'h10, 32'hFF, `HSR_RESP_SLVERR);
    foreach (rows[i])
    begin
      axi_wr(`HSR_OFS_CTRL, {30'h0, rows[i].ctrl}, `HSR_RESP_OKAY);
      @(posedge clock);
      irq_mask <= rows[i].mask;
      int_ack_en <= rows[i].ie;
      prs_clk_stop <= rows[i].prs;
      do_halt();
      chk({cpu_clk_en, mem_retain}, 2'h1);
      @(posedge clock);
      irq_flag <= rows[i].mask;
      repeat (3) @(posedge clock);
      #1;
      chk({cpu_clk_en, run}, {1'h0, rows[i].run});
      @(posedge clock);
      irq_flag <= rows[i].mask | rows[i].flag;
      wait_res(n, g);
      chk(g, 1'h0);
      chk(n, rows[i].vec ? 11 : 4);
      chk({resume.vec, resume.next}, {rows[i].vec, !rows[i].vec});
      @(posedge clock);
      irq_flag <= 8'h00;
    end
    // Halt with a request already pending never gates the core
    @(posedge clock);
    irq_mask <= 8'h00;
    irq_flag <= 8'h01;
    int_ack_en <= 1'h1;
    do_halt();
    wait_res(n, g);
    chk({g, resume.vec}, 2'h1);
    chk(n, 10);
    @(posedge clock);
    irq_flag <= 8'h00;
    do_reset(1'h1);
    do_halt();
    repeat (3) @(posedge clock);
    #1;
    chk(run.wdt_clk_en, 1'h0);
    axi_rd(`HSR_OFS_STAT, 32'h1, `HSR_RESP_OKAY);
    do_reset(1'h0);
    summarize();
  end
endmodule : test_halt_standby_release_control

// *** verilog/hsr_halt_ctrl.sv ***
// Halt state control with AXI4-Lite registers
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "hsr_params.svh"
module hsr_halt_ctrl (
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic [31:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [31:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   halt_exec,
  input  wire logic [`HSR_IRQ_N-1:0]  irq_flag,
  input  wire logic [`HSR_IRQ_N-1:0]  irq_mask,
  input  wire logic                   int_ack_en,
  input  wire logic                   prs_clk_stop,
  input  wire logic                   lsosc_sw_stop_opt,
  output logic                        cpu_clk_en,
  output logic                        mem_retain,
  output hsr_pkg::hsr_run_s           run,
  output hsr_pkg::hsr_resume_s        resume
);

  function automatic logic hsr_is_reg(input logic [31:0] addr);
    hsr_is_reg = (addr == `HSR_OFS_CTRL) || (addr == `HSR_OFS_STAT);
  endfunction : hsr_is_reg

  //////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic        aw_hold_r;
  logic [31:0] awaddr_r;
  logic        w_hold_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [1:0]  ctrl_r;
  logic        last_vec_r;

  wire do_wr    = aw_hold_r && w_hold_r && !bvalid_r;
  wire ctrl_wr  = do_wr && (awaddr_r == `HSR_OFS_CTRL) && wstrb_r[0];
  wire ar_take  = s_axi_arvalid && s_axi_arready;
  wire [31:0] ctrl_word = {30'h0000_0000, ctrl_r};
  wire [31:0] stat_word;
  wire [31:0] rd_word = (s_axi_araddr == `HSR_OFS_CTRL) ? ctrl_word :
                        (s_axi_araddr == `HSR_OFS_STAT) ? stat_word : 32'h0000_0000;

  // Response waits for both halves, so one write never splits
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 32'h0000_0000;
      w_hold_r  <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `HSR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= hsr_is_reg(awaddr_r) ? `HSR_RESP_OKAY : `HSR_RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `HSR_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= hsr_is_reg(s_axi_araddr) ? `HSR_RESP_OKAY : `HSR_RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      ctrl_r <= `HSR_CTRL_RST;
    else if (ctrl_wr)
      ctrl_r <= wdata_r[1:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Halt state machine

  hsr_pkg::hsr_state_e state_r;
  hsr_pkg::hsr_state_e state_nxt;
  logic                vec_r;
  logic                opt_r;
  logic                opt_ok_r;
  logic                rst_pend_r;
  logic                cnt_busy;
  logic                cnt_done;

  wire wake_req = |(irq_flag & ~irq_mask);
  wire in_halt  = (state_r == hsr_pkg::HSR_HALT);
  wire load     = (state_nxt == hsr_pkg::HSR_WAKE) && (state_r != hsr_pkg::HSR_WAKE);
  wire [3:0] wait_val = int_ack_en ? `HSR_WAIT_VEC_CLK : `HSR_WAIT_NXT_CLK;

  assign stat_word = {28'h000_0000, run.wdt_clk_en, last_vec_r,
                      cnt_busy, in_halt};

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      hsr_pkg::HSR_RUN:
        if (halt_exec)
          state_nxt = wake_req ? hsr_pkg::HSR_WAKE : hsr_pkg::HSR_HALT;
      hsr_pkg::HSR_HALT:
        if (wake_req)
          state_nxt = hsr_pkg::HSR_WAKE;
      hsr_pkg::HSR_WAKE:
        if (cnt_done)
          state_nxt = hsr_pkg::HSR_RUN;
      default:
        state_nxt = hsr_pkg::HSR_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r    <= hsr_pkg::HSR_RUN;
      vec_r      <= 1'b0;
      last_vec_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (load)
      begin
        vec_r      <= int_ack_en;
        last_vec_r <= int_ack_en;
      end
    end
  end

  hsr_wait_cnt u_wait (
    .clock    (clock),
    .srst     (srst),
    .load     (load),
    .load_val (wait_val),
    .busy     (cnt_busy),
    .done     (cnt_done)
  );

  // Option byte caught once after reset, not under it
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      opt_r    <= 1'b0;
      opt_ok_r <= 1'b0;
    end
    else if (!opt_ok_r)
    begin
      opt_r    <= lsosc_sw_stop_opt;
      opt_ok_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cpu_clk_en = !in_halt;
  assign mem_retain = in_halt;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      run        <= '0;
      resume     <= '0;
      rst_pend_r <= 1'b1;
    end
    else
    begin
      run.wdt_clk_en <= !(in_halt && opt_r);
      run.adc_run    <= ctrl_r[`HSR_CTRL_ADC] && !prs_clk_stop;
      run.meter_run  <= ctrl_r[`HSR_CTRL_MTR] && !prs_clk_stop;
      resume.vec     <= cnt_done && vec_r;
      resume.next    <= cnt_done && !vec_r;
      resume.rst_fetch <= rst_pend_r;
      rst_pend_r       <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_halt_stays_put: assert property (@(posedge clock) disable iff (srst)
    in_halt && !wake_req |=> in_halt)
    else $error("halt left without a release source");

  a_halt_wake_fast: assert property (@(posedge clock) disable iff (srst)
    in_halt && wake_req |=> state_r == hsr_pkg::HSR_WAKE)
    else $error("pending unmasked request did not wake");

  // Quiet run split at eight, long repeats unroll badly
  a_vec_wait_len: assert property (@(posedge clock) disable iff (srst)
    in_halt && wake_req && int_ack_en |=>
      !resume.vec [*8] ##1 !resume.vec ##1 !resume.vec ##1 resume.vec)
    else $error("vectored resume not after the set wait");

  a_next_wait_len: assert property (@(posedge clock) disable iff (srst)
    in_halt && wake_req && !int_ack_en |=> !resume.next [*3] ##1 resume.next)
    else $error("plain resume not after the set wait");

  a_path_exclusive: assert property (@(posedge clock) disable iff (srst)
    resume.next |-> !resume.vec && !last_vec_r)
    else $error("plain resume taken with acknowledgment");

  a_vec_needs_ack: assert property (@(posedge clock) disable iff (srst)
    resume.vec |-> last_vec_r && !resume.next)
    else $error("vectored resume taken without acknowledgment");

  a_clk_gated: assert property (@(posedge clock) disable iff (srst)
    state_r == hsr_pkg::HSR_RUN && halt_exec && !wake_req |=> !cpu_clk_en && mem_retain)
    else $error("CPU clock not gated on halt");

  a_wdt_feed_cut: assert property (@(posedge clock) disable iff (srst)
    in_halt && opt_r ##1 in_halt |-> !run.wdt_clk_en)
    else $error("watchdog clock not cut");

  a_adc_held_idle: assert property (@(posedge clock) disable iff (srst)
    prs_clk_stop |=> !run.adc_run && !run.meter_run)
    else $error("converter ran without peripheral clock");

  // Fetch pulse is registered, so it shows one edge after release
  a_reset_fetch: assert property (@(posedge clock)
    srst ##1 !srst |->
      state_r == hsr_pkg::HSR_RUN ##1 resume.rst_fetch)
    else $error("no reset vector fetch after reset");

  a_flag_clears: assert property (@(posedge clock) disable iff (srst)
    $fell(in_halt) |-> cnt_busy && $past(wake_req))
    else $error("halt flag cleared without wake");

endmodule : hsr_halt_ctrl

// *** verilog/hsr_params.svh ***
// Constants for the halt standby release control
// Overview of operation
// - While halted the watchdog keeps its clock unless the option byte lets software stop its oscillator.
// - The converter and metering blocks may run while halted but are held idle when the peripheral clock stops.
// - Halt is left only on an unmasked interrupt request or on reset.
// - Halt is left at once when any unmasked interrupt request is pending.
// - An interrupt wake-up with acknowledgment enabled takes the vectored service path.
// - An interrupt wake-up with acknowledgment disabled resumes at the next instruction without service.
// - The wait from release to vectored service is 10 or 11 CPU clocks.
// - The wait from release to the next instruction is 3 or 4 CPU clocks.
// - A reset while halted ends the halt and runs the normal reset sequence from the reset vector.
// - While halted the CPU clock is gated off and memory and port latches hold their values.
`ifndef HSR_PARAMS_SVH
`define HSR_PARAMS_SVH

`define HSR_OFS_CTRL     32'h0000_0000
`define HSR_OFS_STAT     32'h0000_0004
`define HSR_CTRL_ADC     0
`define HSR_CTRL_MTR     1
`define HSR_CTRL_RST     2'h0
`define HSR_IRQ_N        8
`define HSR_WAIT_VEC_CLK 4'hA
`define HSR_WAIT_NXT_CLK 4'h3
`define HSR_RESP_OKAY    2'h0
`define HSR_RESP_SLVERR  2'h2

`endif

// *** verilog/hsr_pkg.sv ***
// Types shared by the halt standby release control
package hsr_pkg;

  typedef enum logic [1:0] {HSR_RUN, HSR_HALT, HSR_WAKE} hsr_state_e;

  typedef struct packed {
    logic vec;
    logic next;
    logic rst_fetch;
  } hsr_resume_s;

  typedef struct packed {
    logic wdt_clk_en;
    logic adc_run;
    logic meter_run;
  } hsr_run_s;

endpackage : hsr_pkg

// *** verilog/hsr_wait_cnt.sv ***
// Wake-up wait counter for the halt standby release control
`timescale 1ns/1ps
module hsr_wait_cnt (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       load,
  input  wire logic [3:0] load_val,
  output logic            busy,
  output logic            done
);

  logic [3:0] cnt_r;

  assign busy = (cnt_r != 4'h0);
  assign done = (cnt_r == 4'h1);

  always_ff @(posedge clock)
  begin
    if (srst)
      cnt_r <= 4'h0;
    else if (load)
      cnt_r <= load_val;
    else if (busy)
      cnt_r <= cnt_r - 4'h1;
  end

endmodule : hsr_wait_cnt
